// ===== bench/addsub_tb.sv
// self-checking bench for the add and subtract datapath
// assumes addsub_pkg and regfile_model; dest 0 stands for none given
`timescale 1ns/1ps
`default_nettype none
module add_subtract_datapath_tb_top
   import addsub_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, rv = 1'b0, ui = 1'b0, sf = 1'b0;
   logic dg = 1'b0, wv, br, il;
   op_t op = OP_ADD;
   logic [3:0] di = '0, fi = '0, si = '0, rdi = '0, wi, fl;
   logic [3:0] efl = FLAGS_RST;
   logic [2:0] sh = '0;
   logic [31:0] a = '0, b = '0, wd, bt, rdd;
   logic [11:0] imm = '0;
   logic [35:0] r;
   int miscompares = 0, compares = 0;
   add_subtract_datapath uut (.CLOCK(clk), .SYS_RST(rst), .REQ_VALID(rv),
      .OP(op), .USE_IMM(ui), .SET_FLAGS(sf), .DEST_GIVEN(dg),
      .DEST_IDX(di), .FIRST_IDX(fi), .SECOND_IDX(si), .SHIFT_AMT(sh),
      .FIRST_SOURCE_REGISTER(a), .FLEXIBLE_SECOND_OPERAND(b),
      .TWELVE_BIT_IMMEDIATE(imm), .WR_VALID(wv), .WR_IDX(wi),
      .WR_DATA(wd), .BRANCH(br), .BRANCH_TARGET(bt), .FLAGS(fl),
      .ILLEGAL(il));
   regfile_model rf (.clk(clk), .rst(rst), .wr_valid(wv), .wr_idx(wi),
      .wr_data(wd), .rd_idx(rdi), .rd_data(rdd));
   initial begin
      forever #25 clk = ~clk;
   end
   // ****************
   // helpers
   // ****************
   task automatic chk(input string n, input logic [31:0] e, s);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [35:0] calc(op_t o, logic [31:0] x, y,
      logic c);
      logic [31:0] p;
      logic [31:0] q;
      logic [32:0] s;
      logic ng;
      logic k;
      logic cy;
      logic v;
      p = (o == OP_REVSUB) ? y : x;
      q = (o == OP_REVSUB) ? x : y;
      ng = o inside {OP_SUB, OP_SUBC, OP_REVSUB};
      k = (o inside {OP_ADC, OP_SUBC}) ? c : ng;
      if (ng) begin
         s = {1'b0, p} - {1'b0, q} - {32'h0, !k};
         v = p[31] != q[31] && s[31] != p[31];
         cy = !s[32];
      end else begin
         s = {1'b0, p} + {1'b0, q} + {32'h0, k};
         v = p[31] == q[31] && s[31] != p[31];
         cy = s[32];
      end
      return {s[31], s[31:0] == 32'h0, cy, v, s[31:0]};
   endfunction : calc
   task automatic go(input op_t o, input logic [3:0] f, d,
      input logic [31:0] x, y, input logic u = 0, s = 0,
      input logic [3:0] q = 4'h0, input logic [2:0] h = 3'h0);
      @(posedge clk);
      rv <= 1'b1;
      op <= o;
      fi <= f;
      di <= d;
      dg <= (d != 4'h0);
      si <= q;
      sh <= h;
      a <= x;
      b <= u ? ~y : y;
      imm <= y[11:0];
      ui <= u;
      sf <= s;
      @(posedge clk);
      rv <= 1'b0;
      #1;
   endtask : go
   task automatic wr(input logic [3:0] i, input logic [31:0] e);
      chk("wr_valid", 32'h1, wv);
      chk("branch", 32'h0, br);
      chk("wr_idx", i, wi);
      chk("wr_data", e, wd);
      chk("flags", efl, fl);
   endtask : wr
   task automatic ill;
      chk("illegal", 32'h1, il);
      chk("wr_valid", 32'h0, wv);
      chk("flags", efl, fl);
   endtask : ill
   // ****************
   // scenarios
   // ****************
   task automatic t_flags;
      logic [31:0] xs [3] = '{32'hffff_fff0, 32'h10, 32'h7fff_ffff};
      logic [31:0] ys [3] = '{32'h10, 32'h20, 32'h1};
      op_t os [5] = '{OP_ADD, OP_ADC, OP_SUB, OP_SUBC, OP_REVSUB};
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 5; j++) begin
            r = calc(os[j], xs[i], ys[i], efl[1]);
            efl = r[35:32];
            go(os[j], 4'h1, 4'h2, xs[i], ys[i], 1'b0, 1'b1, 4'h3);
            wr(4'h2, r[31:0]);
         end
      end
      $display("t_flags done");
   endtask : t_flags
   task automatic t_keep;
      go(OP_SUB, 4'h3, 4'h0, 32'h1000, 32'hfff, 1'b1);
      wr(4'h3, 32'h1);
      go(OP_WADD, 4'h4, 4'h5, 32'h10, 32'h1000_0fff);
      wr(4'h5, 32'h100f);
      go(OP_WSUB, 4'h4, 4'h5, 32'h1000, 32'h8000_0000);
      wr(4'h5, 32'h1000);
      rdi = 4'h3;
      #1;
      chk("regfile", 32'h1, rdd);
      $display("t_keep done");
   endtask : t_keep
   task automatic t_counter;
      go(OP_ADD, 4'hf, 4'h2, 32'h103, 32'h4, 1'b1);
      wr(4'h2, 32'h104);
      go(OP_SUB, 4'hf, 4'h2, 32'h103, 32'h4, 1'b1, 1'b1);
      ill;
      go(OP_ADC, 4'hf, 4'h2, 32'h103, 32'h4, 1'b1);
      ill;
      go(OP_ADD, 4'hf, 4'hf, 32'h103, 32'h11, 1'b0, 1'b0, 4'h1);
      chk("branch", 32'h1, br);
      chk("target", 32'h110, bt);
      chk("wr_valid", 32'h0, wv);
      go(OP_ADD, 4'hf, 4'hf, 32'h103, 32'h11, 1'b0, 1'b0, 4'hf);
      ill;
      $display("t_counter done");
   endtask : t_counter
   task automatic t_stack;
      go(OP_ADD, 4'hd, 4'hd, 32'h100, 32'h8, 1'b0, 1'b0, 4'h2, 3'h3);
      wr(4'hd, 32'h108);
      go(OP_SUB, 4'hd, 4'hd, 32'h100, 32'h8, 1'b0, 1'b0, 4'h2, 3'h4);
      ill;
      go(OP_ADD, 4'h1, 4'hd, 32'h100, 32'h8, 1'b0, 1'b0, 4'h2);
      ill;
      go(OP_REVSUB, 4'hd, 4'hd, 32'h100, 32'h8, 1'b0, 1'b0, 4'h2);
      ill;
      go(OP_ADD, 4'h1, 4'h2, 32'h100, 32'h8, 1'b0, 1'b0, 4'hd);
      ill;
      go(OP_NONE, 4'h1, 4'h2, 32'h100, 32'h8);
      ill;
      $display("t_stack done");
   endtask : t_stack
   task automatic t_reset;
      efl = 4'h2;
      go(OP_SUB, 4'h1, 4'h2, 32'h2, 32'h1, 1'b0, 1'b1, 4'h3);
      wr(4'h2, 32'h1);
      @(posedge clk);
      rst <= 1'b1;
      #1;
      chk("reset flags", FLAGS_RST, fl);
      chk("reset wr_valid", 32'h0, wv);
      chk("reset wr_data", RESULT_RST, wd);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      efl = FLAGS_RST;
      go(OP_ADC, 4'h1, 4'h2, 32'h5, 32'h3);
      wr(4'h2, 32'h8);
      $display("t_reset done");
   endtask : t_reset
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk("flags", efl, fl);
      t_flags;
      t_keep;
      t_counter;
      t_stack;
      t_reset;
      complete_run;
   end
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      complete_run;
   end
endmodule : add_subtract_datapath_tb_top
`default_nettype wire

// ===== bench/regfile_model.sv
// register file model that takes the datapath write-backs
// assumes one clock and the active high async core reset
`timescale 1ns/1ps
`default_nettype none
module regfile_model
   import addsub_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_valid,
   input wire logic [REG_W-1:0] wr_idx,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [REG_W-1:0] rd_idx,
   output logic [DATA_W-1:0] rd_data
);
   // ****************
   // storage
   // ****************
   logic [DATA_W-1:0] regs_ff [16];
   assign rd_data = regs_ff[rd_idx];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            regs_ff[i] <= '0;
         end
      end else if (wr_valid) begin
         regs_ff[wr_idx] <= wr_data;
      end
   end
endmodule : regfile_model
`default_nettype wire

// ===== rtl/addsub_adder.sv
// 33-bit adder with carry-in, producing sum and nzcv
// assumes operands already selected and inverted by caller
`timescale 1ns/1ps
`default_nettype none
module addsub_adder
   import addsub_pkg::*;
#(
   parameter int W = DATA_W
) (
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic cin,
   output logic [W-1:0] sum,
   output logic [3:0] nzcv
);
   logic [W:0] wide;
   assign wide = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
   assign sum = wide[W-1:0];
   assign nzcv = {wide[W-1], (wide[W-1:0] == '0), wide[W],
                  (a[W-1] == b[W-1]) && (wide[W-1] != a[W-1])};
endmodule : addsub_adder
`default_nettype wire

// ===== rtl/addsub_datapath.sv
// add and subtract datapath, one result per accepted request
// assumes decoder presents checked requests; register file writes back
`timescale 1ns/1ps
`default_nettype none
module add_subtract_datapath
   import addsub_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic REQ_VALID,
   input wire op_t OP,
   input wire logic USE_IMM,
   input wire logic SET_FLAGS,
   input wire logic DEST_GIVEN,
   input wire logic [REG_W-1:0] DEST_IDX,
   input wire logic [REG_W-1:0] FIRST_IDX,
   input wire logic [REG_W-1:0] SECOND_IDX,
   input wire logic [2:0] SHIFT_AMT,
   input wire logic [DATA_W-1:0] FIRST_SOURCE_REGISTER,
   input wire logic [DATA_W-1:0] FLEXIBLE_SECOND_OPERAND,
   input wire logic [IMM_W-1:0] TWELVE_BIT_IMMEDIATE,
   output logic WR_VALID,
   output logic [REG_W-1:0] WR_IDX,
   output logic [DATA_W-1:0] WR_DATA,
   output logic BRANCH,
   output logic [DATA_W-1:0] BRANCH_TARGET,
   output logic [3:0] FLAGS,
   output logic ILLEGAL
);
   // ***********************************************************
   // operand path
   // ***********************************************************
   logic [DATA_W-1:0] opa;
   logic [DATA_W-1:0] opb;
   logic imm_form;
   logic is_sub;
   logic is_rsub;
   logic [DATA_W-1:0] add_a;
   logic [DATA_W-1:0] add_b;
   logic cin;
   logic [DATA_W-1:0] sum;
   logic [3:0] nzcv;
   logic [3:0] flags_ff;
   logic carry_op;

   // ***********************************************************
   // operation decode
   // ***********************************************************
   // forms that compute a plus inverted b
   function automatic logic op_subtracts(input op_t o);
      return o == OP_SUB || o == OP_SUBC || o == OP_WSUB;
   endfunction : op_subtracts

   // forms that take the carry flag in
   function automatic logic op_takes_carry(input op_t o);
      return o == OP_ADC || o == OP_SUBC;
   endfunction : op_takes_carry

   // forms with a fixed immediate operand
   function automatic logic op_wide(input op_t o);
      return o == OP_WADD || o == OP_WSUB;
   endfunction : op_wide

   // forms legal with pc as first operand or sp as destination
   function automatic logic op_plain(input op_t o);
      return o == OP_ADD || o == OP_SUB || op_wide(o);
   endfunction : op_plain

   // wide forms act as immediate forms
   assign imm_form = USE_IMM || op_wide(OP);
   assign is_sub = op_subtracts(OP);
   assign is_rsub = OP == OP_REVSUB;
   assign carry_op = op_takes_carry(OP);

   addsub_operand u_operand (
      .first_source_register(FIRST_SOURCE_REGISTER),
      .first_idx(FIRST_IDX),
      .flexible_second_operand(FLEXIBLE_SECOND_OPERAND),
      .twelve_bit_immediate(TWELVE_BIT_IMMEDIATE),
      .use_imm(imm_form),
      .opa(opa),
      .opb(opb)
   );

   // subtraction is a plus not b plus one
   assign add_a = is_rsub ? opb : opa;
   assign add_b = is_rsub ? ~opa : (is_sub ? ~opb : opb);
   assign cin = carry_op ? flags_ff[1]
              : (is_sub || is_rsub);

   addsub_adder #(.W(DATA_W)) u_adder (
      .a(add_a),
      .b(add_b),
      .cin(cin),
      .sum(sum),
      .nzcv(nzcv)
   );

   // ***********************************************************
   // legality and destination
   // ***********************************************************
   logic plain_op;
   logic [REG_W-1:0] dest;
   logic pc_branch;
   logic bad_pc_first;
   logic bad_sp_dest;
   logic bad_second;
   logic illegal;

   assign plain_op = op_plain(OP);
   assign dest = DEST_GIVEN ? DEST_IDX : FIRST_IDX;
   assign pc_branch = dest == PC_IDX && FIRST_IDX == PC_IDX
                      && OP == OP_ADD && !imm_form && !SET_FLAGS;
   assign bad_pc_first = FIRST_IDX == PC_IDX && !pc_branch
                         && !(plain_op && imm_form && !SET_FLAGS);
   assign bad_sp_dest = dest == SP_IDX && !(plain_op
                        && FIRST_IDX == SP_IDX
                        && SHIFT_AMT <= MAX_SP_SHIFT);
   assign bad_second = !imm_form && (SECOND_IDX == SP_IDX
                       || SECOND_IDX == PC_IDX);
   assign illegal = OP == OP_NONE || bad_pc_first || bad_sp_dest
                    || bad_second || (dest == PC_IDX && !pc_branch);

   // ***********************************************************
   // result registers
   // ***********************************************************
   logic go;
   logic nxt_wr_valid;
   logic nxt_branch;
   logic [3:0] nxt_flags;
   logic wr_valid_ff;
   logic branch_ff;
   logic illegal_ff;
   logic [REG_W-1:0] wr_idx_ff;
   logic [DATA_W-1:0] wr_data_ff;
   logic [DATA_W-1:0] target_ff;

   assign go = REQ_VALID && !illegal;
   assign nxt_wr_valid = go && !pc_branch;
   assign nxt_branch = go && pc_branch;
   assign nxt_flags = (go && SET_FLAGS) ? nzcv : flags_ff;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_valid_ff <= 1'b0;
      end else begin
         wr_valid_ff <= nxt_wr_valid;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         branch_ff <= 1'b0;
      end else begin
         branch_ff <= nxt_branch;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         illegal_ff <= 1'b0;
      end else begin
         illegal_ff <= REQ_VALID && illegal;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_idx_ff <= '0;
      end else begin
         wr_idx_ff <= dest;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_data_ff <= RESULT_RST;
      end else begin
         wr_data_ff <= sum;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         target_ff <= RESULT_RST;
      end else begin
         target_ff <= {sum[DATA_W-1:1], 1'b0};
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         flags_ff <= FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   assign WR_VALID = wr_valid_ff;
   assign WR_IDX = wr_idx_ff;
   assign WR_DATA = wr_data_ff;
   assign BRANCH = branch_ff;
   assign BRANCH_TARGET = target_ff;
   assign FLAGS = flags_ff;
   assign ILLEGAL = illegal_ff;

   // ***********************************************************
   // checks
   // ***********************************************************
   a_add_result: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_ADD && !pc_branch
      |=> WR_DATA == $past(opa) + $past(opb))
      else $error("add result wrong");
   a_adc_result: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_ADC |=> WR_DATA == $past(opa) + $past(opb)
      + {31'h0, $past(flags_ff[1])})
      else $error("add with carry wrong");
   a_sub_result: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_SUB |=> WR_DATA == $past(opa) - $past(opb))
      else $error("subtract wrong");
   a_subc_result: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_SUBC |=> WR_DATA == $past(opa) - $past(opb)
      - {31'h0, !$past(flags_ff[1])})
      else $error("subtract with carry wrong");
   a_rsub_result: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_REVSUB |=> WR_DATA == $past(opb) - $past(opa))
      else $error("reverse subtract wrong");
   a_dest_default: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && !DEST_GIVEN && !pc_branch
      |=> WR_VALID && WR_IDX == $past(FIRST_IDX))
      else $error("destination default wrong");
   a_flags_hold: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      !(go && SET_FLAGS) |=> $stable(FLAGS))
      else $error("flags changed without suffix");
   a_flags_load: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && SET_FLAGS |=> FLAGS == $past(nzcv))
      else $error("flags not loaded from result");
   a_sub_carry: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && SET_FLAGS && OP == OP_SUB
      |=> FLAGS[1] == ($past(opa) >= $past(opb)))
      else $error("borrow sense wrong");
   a_add_carry: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && SET_FLAGS && OP == OP_ADD
      |=> {FLAGS[1], WR_DATA} == {1'b0, $past(opa)} + {1'b0, $past(opb)})
      else $error("add carry out wrong");
   a_pc_align: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      FIRST_IDX == PC_IDX |-> opa[1:0] == 2'h0)
      else $error("pc base not aligned");
   a_pc_base_sum: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && FIRST_IDX == PC_IDX && OP == OP_ADD && imm_form
      |=> WR_DATA == {$past(FIRST_SOURCE_REGISTER[DATA_W-1:2]), 2'h0}
      + {20'h0, $past(TWELVE_BIT_IMMEDIATE)})
      else $error("pc based sum wrong");
   a_branch_even: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      BRANCH |-> !BRANCH_TARGET[0] && !WR_VALID)
      else $error("branch target odd");
   a_branch_target: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && pc_branch |=> BRANCH
      && BRANCH_TARGET == (($past(opa) + $past(opb)) & ~32'h1))
      else $error("branch target wrong");
   a_wide_same: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_WADD |=> WR_DATA == $past(opa)
      + {20'h0, $past(TWELVE_BIT_IMMEDIATE)})
      else $error("wide add differs");
   a_wsub_same: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      go && OP == OP_WSUB |=> WR_DATA == $past(opa)
      - {20'h0, $past(TWELVE_BIT_IMMEDIATE)})
      else $error("wide subtract differs");
   a_pc_refuse: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      REQ_VALID && FIRST_IDX == PC_IDX && SET_FLAGS |=> ILLEGAL)
      else $error("pc operand with flags accepted");
   a_sp_refuse: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      REQ_VALID && dest == SP_IDX && FIRST_IDX != SP_IDX |=> ILLEGAL)
      else $error("sp destination accepted");
   a_second_refuse: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      REQ_VALID && !imm_form
      && (SECOND_IDX == SP_IDX || SECOND_IDX == PC_IDX) |=> ILLEGAL)
      else $error("sp or pc second operand accepted");
   a_refused_quiet: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      REQ_VALID && illegal
      |=> ILLEGAL && !WR_VALID && !BRANCH && $stable(FLAGS))
      else $error("refused request had effect");
   a_one_answer: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      REQ_VALID |=> $onehot({WR_VALID, BRANCH, ILLEGAL}))
      else $error("request answer not unique");
   a_no_answer: assert property (
      @(posedge CLOCK) disable iff (SYS_RST)
      !REQ_VALID |=> !WR_VALID && !BRANCH && !ILLEGAL)
      else $error("answer without request");
endmodule : add_subtract_datapath
`default_nettype wire

// ===== rtl/addsub_operand.sv
// operand selection: first operand alignment and second operand choice
// assumes second operand already shifted by decoder
`timescale 1ns/1ps
`default_nettype none
module addsub_operand
   import addsub_pkg::*;
(
   input wire logic [DATA_W-1:0] first_source_register,
   input wire logic [REG_W-1:0] first_idx,
   input wire logic [DATA_W-1:0] flexible_second_operand,
   input wire logic [IMM_W-1:0] twelve_bit_immediate,
   input wire logic use_imm,
   output logic [DATA_W-1:0] opa,
   output logic [DATA_W-1:0] opb
);
   logic pc_base;
   assign pc_base = (first_idx == PC_IDX);
   assign opa = pc_base ?
      {first_source_register[DATA_W-1:2], WORD_ALIGN_MASK}
      : first_source_register;
   assign opb = use_imm ?
      {{(DATA_W-IMM_W){1'b0}}, twelve_bit_immediate}
      : flexible_second_operand;
endmodule : addsub_operand
`default_nettype wire

// ===== rtl/addsub_pkg.sv
// constants and types for the add and subtract datapath
// assumes a single clock domain shared with decoder and register file
package addsub_pkg;
   localparam int DATA_W = 32;
   localparam int IMM_W = 12;
   localparam int REG_W = 4;
   localparam logic [REG_W-1:0] SP_IDX = 4'hd;
   localparam logic [REG_W-1:0] PC_IDX = 4'hf;
   localparam logic [2:0] MAX_SP_SHIFT = 3'h3;
   localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [1:0] WORD_ALIGN_MASK = 2'h0;

   typedef enum logic [2:0] {
      OP_ADD = 3'b000,
      OP_ADC = 3'b001,
      OP_SUB = 3'b010,
      OP_SUBC = 3'b011,
      OP_REVSUB = 3'b100,
      OP_WADD = 3'b101,
      OP_WSUB = 3'b110,
      OP_NONE = 3'b111
   } op_t;
endpackage : addsub_pkg
